// ---- dv/cart_host_props.sv ----
/*
 Pin checker for the cartridge host controller.
 Assumes it is bound to cart_host and sees only its ports.
*/
`timescale 1ns/1ps
`include "cart_host_consts.svh"

module cart_host_props (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               req_write,
	input wire logic               req_ready,
	input wire logic               rsp_valid,
	input wire logic [1:0]         density,
	input wire logic [`ADDR_W-1:0] byte_address_lines,
	input wire logic               select_n,
	input wire logic               output_gate_n,
	input wire logic               write_strobe_n,
	input wire logic               data_oe
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	function automatic logic [`ADDR_W-1:0] amask(input logic [1:0] d);
		return d == 2'h0 ? `ADDR_MASK_2K : d == 2'h1 ? `ADDR_MASK_8K :
			d == 2'h2 ? `ADDR_MASK_16K : `ADDR_MASK_32K;
	endfunction

	sequence s_wr2;
		!write_strobe_n ##1 !write_strobe_n;
	endsequence
	// Ten cycles of access, split to keep repetition counts small
	sequence s_acc;
		(!select_n && !output_gate_n)[*8] ##1 (!select_n && !output_gate_n)[*2];
	endsequence

	property p_wr_pins;
		!write_strobe_n |-> data_oe && output_gate_n && !select_n;
	endproperty
	property p_addr_hold;
		s_wr2 |-> $stable(byte_address_lines);
	endproperty
	property p_pulse;
		$fell(write_strobe_n) |-> (!write_strobe_n && !select_n)[*7];
	endproperty
	property p_recov;
		$rose(write_strobe_n) |-> (write_strobe_n && select_n)[*6];
	endproperty
	property p_mask;
		!select_n |-> (byte_address_lines & ~amask(density)) == 15'h0000;
	endproperty
	property p_access;
		$fell(output_gate_n) |-> s_acc;
	endproperty
	property p_rsp;
		req_ready && !req_write |-> ##[10:20] rsp_valid;
	endproperty
	property p_no_fight;
		!output_gate_n |-> !data_oe;
	endproperty

	a_wr_pins: assert property (p_wr_pins) else $error("write pins");
	a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
	a_pulse: assert property (p_pulse) else $error("short pulse");
	a_recov: assert property (p_recov) else $error("short recovery");
	a_mask: assert property (p_mask) else $error("upper addr set");
	a_access: assert property (p_access) else $error("short access");
	a_rsp: assert property (p_rsp) else $error("no read reply");
	a_no_fight: assert property (p_no_fight) else $error("bus fight");
endmodule

// ---- dv/cart_model.sv ----
/*
 Behavioural cartridge: byte array, access delay, supply, battery and
 protect guards. Assumes pins come straight from the host controller.
*/
`timescale 1ns/1ps
`include "cart_host_consts.svh"

module cart_model #(
	parameter int ACCESS_NS = 200
) (
	input  wire logic [`ADDR_W-1:0] byte_address_lines,
	input  wire logic               rst_n,
	input  wire logic               select_n,
	input  wire logic               output_gate_n,
	input  wire logic               write_strobe_n,
	input  wire logic [`DATA_W-1:0] data_out,
	input  wire logic               data_oe,
	input  wire logic               protect,
	input  wire logic               supply_low,
	input  wire logic               batt_a_low,
	input  wire logic               batt_b_low,
	output wire logic [`DATA_W-1:0] data_in
);
	logic [`DATA_W-1:0] mem [0:32767];
	logic [`DATA_W-1:0] last = 8'h00;
	int                 ncyc = 0;
	wire                valid_d;
	// Low supply loses every cycle; battery loses the second only when both cells are flat
	wire off = supply_low || (batt_a_low && batt_b_low && ncyc == 2);
	wire drv = !select_n && !output_gate_n && write_strobe_n && !off;

	assign #(ACCESS_NS) valid_d = drv;
	// Floating bus shows the inverse of the last byte, never a stale match
	assign data_in = data_oe ? data_out :
		(drv && valid_d) ? mem[byte_address_lines] : ~last;

	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	always @(negedge rst_n)
		ncyc = 0;
	always @(negedge select_n)
		ncyc++;
	always @*
		if (drv && valid_d)
			last = mem[byte_address_lines];
	always @(posedge (select_n | write_strobe_n))
		if (!off && !protect)
			mem[byte_address_lines] = data_out;
endmodule

// ---- dv/tb_top.sv ----
/*
 Bench for the cartridge host controller against a cartridge model.
 Assumes package, header, design, model and checker compiled first.
*/
`timescale 1ns/1ps
`include "cart_host_consts.svh"

module tb_top;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               req_valid = 1'b0;
	logic               req_write = 1'b0;
	logic [`ADDR_W-1:0] req_addr = 15'h0000;
	logic [`DATA_W-1:0] req_wdata = 8'h00;
	logic [1:0]         density = 2'h3;
	logic               check_start = 1'b0;
	logic               protect = 1'b0;
	logic               supply_low = 1'b0;
	logic               batt_a_low = 1'b0;
	logic               batt_b_low = 1'b0;
	logic [`DATA_W-1:0] data_in, rsp_rdata, data_out;
	logic [`ADDR_W-1:0] byte_address_lines;
	logic               req_ready, rsp_valid, check_done, check_doubtful;
	logic               select_n, output_gate_n, write_strobe_n, data_oe;
	int                 num_errors = 0;
	int                 comparisons = 0;
	int                 cycles = 0;

	always #12.5 clk = ~clk;

	cart_host #(.POWER_UP_CYCLES(10)) u_dut(.clk, .rst_n, .req_valid,
		.req_write, .req_addr, .req_wdata, .density, .check_start, .data_in,
		.req_ready, .rsp_valid, .rsp_rdata, .check_done, .check_doubtful,
		.byte_address_lines, .select_n, .output_gate_n, .write_strobe_n,
		.data_out, .data_oe);
	cart_model u_cart(.byte_address_lines, .rst_n, .select_n, .output_gate_n,
		.write_strobe_n, .data_out, .data_oe, .protect, .supply_low,
		.batt_a_low, .batt_b_low, .data_in);

	task automatic summarize;
		if (num_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic power_on;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (16) @(posedge clk);
		#1;
	endtask

	// Writes return once select is back high, so guards change between cycles
	task automatic issue(input logic w, input logic [`ADDR_W-1:0] a,
		input logic [`DATA_W-1:0] d, output logic [`DATA_W-1:0] q);
		int n;
		n = 0;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1 && ++n < 99);
		chk("ready", 8'h01, {7'h00, req_ready});
		#1 req_valid = 1'b0;
		q = 8'h00;
		do @(posedge clk); while ((w ? !select_n : !rsp_valid) && ++n < 199);
		chk("cycle_end", 8'h01, {7'h00, w ? select_n : rsp_valid});
		if (!w)
			q = rsp_rdata;
		#1;
	endtask

	task automatic t_rw;
		logic [`DATA_W-1:0] q;
		issue(1'b1, 15'h7abc, 8'h3c, q);
		issue(1'b1, 15'h7abd, 8'hc3, q);
		issue(1'b0, 15'h7abc, 8'h00, q);
		chk("rd_a", 8'h3c, q);
		issue(1'b0, 15'h7abd, 8'h00, q);
		chk("rd_b", 8'hc3, q);
	endtask

	task automatic t_dens;
		logic [`DATA_W-1:0] q;
		logic [`ADDR_W-1:0] m [3];
		m = '{`ADDR_MASK_2K, `ADDR_MASK_8K, `ADDR_MASK_16K};
		for (int i = 0; i < 3; i++)
		begin
			density = 2'(i);
			issue(1'b1, 15'h7fff, 8'h50 + 8'(i), q);
			density = 2'h3;
			issue(1'b0, m[i], 8'h00, q);
			chk("dens", 8'h50 + 8'(i), q);
		end
	endtask

	task automatic t_guard;
		logic [`DATA_W-1:0] q;
		issue(1'b1, 15'h0100, 8'h11, q);
		protect = 1'b1;
		issue(1'b1, 15'h0100, 8'hee, q);
		protect = 1'b0;
		supply_low = 1'b1;
		issue(1'b1, 15'h0100, 8'hdd, q);
		supply_low = 1'b0;
		issue(1'b0, 15'h0100, 8'h00, q);
		chk("guard", 8'h11, q);
		supply_low = 1'b1;
		issue(1'b0, 15'h0100, 8'h00, q);
		chk("low_rd", 8'hee, q);
		supply_low = 1'b0;
	endtask

	task automatic t_batt(input logic [1:0] lows, input logic exp);
		int n;
		n = 0;
		{batt_a_low, batt_b_low} = lows;
		power_on();
		check_start = 1'b1;
		@(posedge clk);
		#1 check_start = 1'b0;
		do @(posedge clk); while (check_done !== 1'b1 && ++n < 300);
		chk("check_done", 8'h01, {7'h00, check_done});
		#1 chk("doubt", {7'h00, exp}, {7'h00, check_doubtful});
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			summarize();
		end
	end

	initial
	begin
		power_on();
		t_rw();
		t_dens();
		t_guard();
		t_batt(2'b10, 1'b0);
		t_batt(2'b11, 1'b1);
		summarize();
	end
endmodule

bind cart_host cart_host_props u_props(.clk, .rst_n, .req_write, .req_ready,
	.rsp_valid, .density, .byte_address_lines, .select_n, .output_gate_n,
	.write_strobe_n, .data_oe);

// ---- inc/cart_host_consts.svh ----
/*
 Timing counts and field sizes for the cartridge host controller.
 Assumes a 40 MHz clock; included by bare name from the rtl files.
*/
`ifndef CART_HOST_CONSTS_SVH
`define CART_HOST_CONSTS_SVH

`define CLK_PERIOD_NS          25
// Read cycle time, least (ns)
`define READ_CYCLE_NS          250
// Access delays, longest (ns); sampling waits the full figure
`define ADDRESS_ACCESS_NS      250
`define SELECT_ACCESS_NS       250
`define OUTPUT_GATE_ACCESS_NS  125
// Write pulse width, least (ns)
`define WRITE_PULSE_NS         170
// Address setup before strobe (ns)
`define ADDRESS_SETUP_NS       0
// Strobe high before a new cycle, least (ns)
`define WRITE_RECOVERY_NS      20
// Output float after deselect, longest (ns)
`define DESELECT_FLOAT_NS      125
// Power-up wait with select high, least (ms)
`define POWER_UP_WAIT_MS       2

`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX1(v) (((v) < 1) ? 1 : (v))

`define READ_CYCLES     `MAX1(`CEIL_CYC(`SELECT_ACCESS_NS))
`define WRITE_CYCLES    `MAX1(`CEIL_CYC(`WRITE_PULSE_NS))
`define SETUP_CYCLES    `MAX1(`CEIL_CYC(`ADDRESS_SETUP_NS))
`define RECOVERY_CYCLES `MAX1(`CEIL_CYC(`WRITE_RECOVERY_NS + \
	`DESELECT_FLOAT_NS))
`define POWER_UP_CYCLES (`POWER_UP_WAIT_MS * 1000000 / `CLK_PERIOD_NS)

`define TIMER_W         17
`define ADDR_W          15
`define DATA_W          8

`define ADDR_MASK_2K    15'h07ff
`define ADDR_MASK_8K    15'h1fff
`define ADDR_MASK_16K   15'h3fff
`define ADDR_MASK_32K   15'h7fff

`endif

// ---- inc/cart_host_pkg.sv ----
/*
 Types for the cartridge host controller.
 No assumptions beyond a SystemVerilog compiler.
*/
package cart_host_pkg;

	typedef enum logic [3:0] {
		ST_POWER_UP  = 4'b0000,
		ST_IDLE      = 4'b0001,
		ST_RD_SETUP  = 4'b0010,
		ST_RD_WAIT   = 4'b0011,
		ST_WR_SETUP  = 4'b0100,
		ST_WR_PULSE  = 4'b0101,
		ST_RECOVER   = 4'b0110,
		ST_DONE      = 4'b0111
	} bus_state_t;

	typedef enum logic [2:0] {
		CK_IDLE  = 3'b000,
		CK_READ1 = 3'b001,
		CK_WRITE = 3'b010,
		CK_READ2 = 3'b011,
		CK_END   = 3'b100
	} check_state_t;

	typedef enum logic [1:0] {
		DENS_2K  = 2'b00,
		DENS_8K  = 2'b01,
		DENS_16K = 2'b10,
		DENS_32K = 2'b11
	} density_t;

endpackage

// ---- rtl/cart_host.sv ----
/*
 Host controller that drives a byte-wide nonvolatile cartridge through its
 address, select, output enable, write strobe and data pins, and runs the
 power-up battery check. Assumes a 40 MHz clock and pins on the same board.
*/
// Overview of operation
// - Host holds address steady through the whole write cycle.
// - Host keeps strobe high for recovery before next cycle.
// - Host keeps output gate high during writes.
// - Host reads, writes altered data, reads back; mismatch means doubt.
// - Host ties unused upper address lines low per density.
`timescale 1ns/1ps
`include "cart_host_consts.svh"

module cart_host #(
	parameter int POWER_UP_CYCLES = `POWER_UP_CYCLES
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 req_valid,
	input  wire logic                 req_write,
	input  wire logic [`ADDR_W-1:0]   req_addr,
	input  wire logic [`DATA_W-1:0]   req_wdata,
	input  wire logic [1:0]           density,
	input  wire logic                 check_start,
	input  wire logic [`DATA_W-1:0]   data_in,
	output logic                      req_ready,
	output logic                      rsp_valid,
	output logic [`DATA_W-1:0]        rsp_rdata,
	output logic                      check_done,
	output logic                      check_doubtful,
	output logic [`ADDR_W-1:0]        byte_address_lines,
	output logic                      select_n,
	output logic                      output_gate_n,
	output logic                      write_strobe_n,
	output logic [`DATA_W-1:0]        data_out,
	output logic                      data_oe
);

	localparam logic [`TIMER_W-1:0] READ_CNT  = `TIMER_W'(`READ_CYCLES);
	localparam logic [`TIMER_W-1:0] WRITE_CNT = `TIMER_W'(`WRITE_CYCLES);
	localparam logic [`TIMER_W-1:0] SETUP_CNT = `TIMER_W'(`SETUP_CYCLES);
	localparam logic [`TIMER_W-1:0] REC_CNT   = `TIMER_W'(`RECOVERY_CYCLES);
	localparam logic [`TIMER_W-1:0] PWR_CNT   = `TIMER_W'(POWER_UP_CYCLES);

	cart_host_pkg::bus_state_t   st_q;
	cart_host_pkg::check_state_t ck_q;
	logic [`DATA_W-1:0]          pin_meta_q;
	logic [`DATA_W-1:0]          pin_sync_q;
	logic [`DATA_W-1:0]          first_q;
	logic                        op_write_q;
	logic                        busy_write;
	logic [`ADDR_W-1:0]          op_addr;
	logic [`DATA_W-1:0]          op_wdata;
	logic                        timer_load;
	logic [`TIMER_W-1:0]         timer_count;
	logic                        timer_done;
	logic [`ADDR_W-1:0]          addr_mask;
	logic                        issue;
	logic                        check_issue;
	logic                        ck_active;
	logic                        timer_done_seen_q;

	// Data pins come from another part; two flops before use
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end
		else
		begin
			pin_meta_q <= data_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	always_comb
	begin
		case (cart_host_pkg::density_t'(density))
			cart_host_pkg::DENS_2K:  addr_mask = `ADDR_MASK_2K;
			cart_host_pkg::DENS_8K:  addr_mask = `ADDR_MASK_8K;
			cart_host_pkg::DENS_16K: addr_mask = `ADDR_MASK_16K;
			default:                 addr_mask = `ADDR_MASK_32K;
		endcase
	end

	assign ck_active   = (ck_q != cart_host_pkg::CK_IDLE) &&
		(ck_q != cart_host_pkg::CK_END);
	assign check_issue = ck_active && (st_q == cart_host_pkg::ST_IDLE);
	assign issue       = (st_q == cart_host_pkg::ST_IDLE) &&
		(check_issue || (req_valid && !ck_active && !check_start));
	// Check uses address 0 and the complement of what it read
	assign busy_write  = check_issue ? (ck_q == cart_host_pkg::CK_WRITE)
		: req_write;
	assign op_addr     = check_issue ? '0 : (req_addr & addr_mask);
	assign op_wdata    = check_issue ? ~first_q : req_wdata;

	always_comb
	begin
		timer_load  = 1'b0;
		timer_count = SETUP_CNT;
		if (issue)
			timer_load = 1'b1;
		else if (timer_done)
		begin
			case (st_q)
				cart_host_pkg::ST_RD_SETUP:
				begin
					timer_load  = 1'b1;
					timer_count = READ_CNT;
				end
				cart_host_pkg::ST_WR_SETUP:
				begin
					timer_load  = 1'b1;
					timer_count = WRITE_CNT;
				end
				cart_host_pkg::ST_RD_WAIT, cart_host_pkg::ST_WR_PULSE:
				begin
					timer_load  = 1'b1;
					timer_count = REC_CNT;
				end
				default:
				begin
					timer_load  = 1'b0;
					timer_count = SETUP_CNT;
				end
			endcase
		end
		if (!rst_n)
			timer_count = PWR_CNT;
	end

	cycle_timer #(
		.W (`TIMER_W)
	) u_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.load    (timer_load || st_q == cart_host_pkg::ST_POWER_UP &&
			!timer_done_seen_q),
		.count   ((st_q == cart_host_pkg::ST_POWER_UP) ? PWR_CNT
			: timer_count),
		.expired (timer_done)
	);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_done_seen_q <= 1'b0;
		else if (st_q == cart_host_pkg::ST_POWER_UP)
			timer_done_seen_q <= 1'b1;
	end

	// Bus sequencer; select stays high through the power-up wait
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= cart_host_pkg::ST_POWER_UP;
		else
		begin
			case (st_q)
				cart_host_pkg::ST_POWER_UP:
					if (timer_done && timer_done_seen_q)
						st_q <= cart_host_pkg::ST_IDLE;
				cart_host_pkg::ST_IDLE:
					if (issue)
						st_q <= busy_write ? cart_host_pkg::ST_WR_SETUP
							: cart_host_pkg::ST_RD_SETUP;
				cart_host_pkg::ST_RD_SETUP:
					if (timer_done)
						st_q <= cart_host_pkg::ST_RD_WAIT;
				cart_host_pkg::ST_WR_SETUP:
					if (timer_done)
						st_q <= cart_host_pkg::ST_WR_PULSE;
				cart_host_pkg::ST_RD_WAIT, cart_host_pkg::ST_WR_PULSE:
					if (timer_done)
						st_q <= cart_host_pkg::ST_RECOVER;
				cart_host_pkg::ST_RECOVER:
					if (timer_done)
						st_q <= cart_host_pkg::ST_IDLE;
				default:
					st_q <= cart_host_pkg::ST_IDLE;
			endcase
		end
	end

	// Pins: address latched at issue, held to end of recovery
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			byte_address_lines <= '0;
			data_out           <= '0;
			op_write_q         <= 1'b0;
		end
		else if (issue)
		begin
			byte_address_lines <= op_addr;
			data_out           <= op_wdata;
			op_write_q         <= busy_write;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			select_n       <= 1'b1;
			output_gate_n  <= 1'b1;
			write_strobe_n <= 1'b1;
			data_oe        <= 1'b0;
		end
		else
		begin
			// Select low around reads and writes, gate low only around a read, where strobe stays high
			select_n <= !(st_q == cart_host_pkg::ST_RD_SETUP ||
				st_q == cart_host_pkg::ST_RD_WAIT && !timer_done ||
				st_q == cart_host_pkg::ST_WR_SETUP ||
				st_q == cart_host_pkg::ST_WR_PULSE && !timer_done);
			output_gate_n <= !((st_q == cart_host_pkg::ST_RD_SETUP ||
				st_q == cart_host_pkg::ST_RD_WAIT) && !timer_done);
			// Strobe falls after select and rises on the same edge as select
			write_strobe_n <= !(st_q == cart_host_pkg::ST_WR_SETUP &&
				timer_done || st_q == cart_host_pkg::ST_WR_PULSE &&
				!timer_done);
			// Drive data only in a write; gate is high there already
			data_oe <= (st_q == cart_host_pkg::ST_WR_SETUP ||
				st_q == cart_host_pkg::ST_WR_PULSE) ||
				(issue && busy_write);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			req_ready <= 1'b0;
		end
		else
		begin
			// Sample at the end of the full read access
			rsp_valid <= st_q == cart_host_pkg::ST_RD_WAIT && timer_done &&
				!ck_active;
			if (st_q == cart_host_pkg::ST_RD_WAIT && timer_done)
				rsp_rdata <= pin_sync_q;
			req_ready <= issue && !check_issue;
		end
	end

	// Battery check: read, write inverse, read back and compare
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ck_q           <= cart_host_pkg::CK_IDLE;
			first_q        <= '0;
			check_done     <= 1'b0;
			check_doubtful <= 1'b0;
		end
		else
		begin
			check_done <= 1'b0;
			case (ck_q)
				cart_host_pkg::CK_IDLE, cart_host_pkg::CK_END:
					if (check_start && st_q == cart_host_pkg::ST_IDLE)
					begin
						ck_q           <= cart_host_pkg::CK_READ1;
						check_doubtful <= 1'b0;
					end
				default:
					if (st_q == cart_host_pkg::ST_RD_WAIT && timer_done ||
						st_q == cart_host_pkg::ST_WR_PULSE && timer_done)
					begin
						if (ck_q == cart_host_pkg::CK_READ1)
						begin
							first_q <= pin_sync_q;
							ck_q    <= cart_host_pkg::CK_WRITE;
						end
						else if (ck_q == cart_host_pkg::CK_WRITE)
							ck_q <= cart_host_pkg::CK_READ2;
						else
						begin
							// Mismatch: battery low or write blocked
							check_doubtful <= pin_sync_q != ~first_q;
							check_done     <= 1'b1;
							ck_q           <= cart_host_pkg::CK_END;
						end
					end
			endcase
		end
	end

endmodule

// ---- rtl/cycle_timer.sv ----
/*
 Down counter that times one phase of a cartridge bus cycle.
 Assumes one clock; load has priority over counting.
*/
`timescale 1ns/1ps
`include "cart_host_consts.svh"

module cycle_timer #(
	parameter int W = `TIMER_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              expired
);

	logic [W-1:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else if (load)
			cnt_q <= count;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	// Bare count compare; gating with load would loop through the sequencer
	assign expired = (cnt_q == '0);

endmodule
